// [core/bpd_pkg.sv]
package bpd_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the AXI4-Lite bus.
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;   // pwm_control_reg.
  localparam logic [7:0] OFF_DUTY = 8'h04;   // duty_high_reg.
  localparam logic [7:0] OFF_PERIOD = 8'h08; // period_reg.
  localparam logic [7:0] OFF_TCTRL = 8'h0C;  // period_timer_control.
  localparam logic [7:0] OFF_FLAG = 8'h10;   // peripheral_flag_reg.
  localparam logic [7:0] OFF_DELAY = 8'h14;  // deadband_delay_reg.
  localparam logic [7:0] OFF_TIMER = 8'h18;  // period_timer, read only.
  localparam logic [7:0] OFF_PINDIR = 8'h1C; // pin_direction_reg.

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int CTRL_CFG_LSB = 6;   // output_config_field <7:6>.
  localparam int CTRL_DLO_LSB = 4;   // Low duty bits <5:4>.
  localparam int TCTRL_ON_BIT = 2;   // period_timer_on.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [2:0] RST_TCTRL = 3'h0;
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic [3:0] RST_PINDIR = 4'hF;
  localparam logic [1:0] PWM_MODE_ON = 2'h3; // module_mode_field <3:2>.

  // Output configurations.
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_REV = 2'h3;

  // Timing: oscillator periods per instruction cycle.
  localparam int OSC_PER_INSTR = 4;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Direction change sequencer states.
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_TURN = 2'b10
  } bpd_dir_state_type;

  // One register write, as issued by the bus slave.
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } bpd_wr_type;

  // True when an address names a register.
  function automatic logic bpd_hit(input logic [7:0] a);
    bpd_hit = (a == OFF_CTRL) || (a == OFF_DUTY) || (a == OFF_PERIOD) ||
      (a == OFF_TCTRL) || (a == OFF_FLAG) || (a == OFF_DELAY) ||
      (a == OFF_TIMER) || (a == OFF_PINDIR);
  endfunction

endpackage

// [core/bpd_axil.sv]
`timescale 1ns/100ps
module bpd_axil
  import bpd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output bpd_wr_type o_wr,
  output logic [7:0] o_rd_addr,
  input wire logic [31:0] i_rd_data
);

  // ----------------------------------------------------------------
  // Write path.
  // ----------------------------------------------------------------
  // Address and data are taken together, once both are offered.
  // The register write is issued on the same edge as the handshake.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_wr <= '0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (i_ce) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_wr.en <= 1'b0;
      if (i_awvalid && i_wvalid && !o_awready && !o_bvalid) begin
        o_awready <= 1'b1;
        o_wready <= 1'b1;
        o_wr <= '{en: 1'b1, addr: i_awaddr, data: i_wdata, strb: i_wstrb};
      end
      // Response follows the handshake by one cycle.
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end else if (o_awready) begin
        o_bvalid <= 1'b1;
        o_bresp <= bpd_hit(o_wr.addr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------
  assign o_rd_addr = i_araddr;

  // Data are captured with arready and shown one cycle later.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= RESP_OKAY;
    end else if (i_ce) begin
      o_arready <= 1'b0;
      if (i_arvalid && !o_arready && !o_rvalid) begin
        o_arready <= 1'b1;
        o_rdata <= i_rd_data;
        o_rresp <= bpd_hit(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end else if (o_arready) begin
        o_rvalid <= 1'b1;
      end
    end
  end

endmodule

// [core/bpd_deadband.sv]
`timescale 1ns/100ps
module bpd_deadband
  import bpd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_enable,
  input wire logic [7:0] i_delay,
  input wire logic [1:0] i_raw,
  output logic [1:0] o_out
);

  // ----------------------------------------------------------------
  // One delay channel per half-bridge output.
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      logic prev;        // Raw level one cycle ago.
      logic busy;        // Delay is running.
      logic [9:0] cnt;   // Oscillator periods left.

      // Rising edges wait the delay; falling edges pass at once.
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          prev <= 1'b0;
          busy <= 1'b0;
          cnt <= 10'h000;
          o_out[g] <= 1'b0;
        end else if (i_ce) begin
          prev <= i_raw[g];
          if (!i_enable) begin
            // Bypass: no delay on any edge.
            busy <= 1'b0;
            o_out[g] <= i_raw[g];
          end else if (!i_raw[g]) begin
            // Inactive edge is never delayed; a short pulse is lost.
            busy <= 1'b0;
            o_out[g] <= 1'b0;
          end else if (!prev) begin
            if (i_delay == 8'h00) begin
              o_out[g] <= 1'b1;
            end else begin
              busy <= 1'b1;
              cnt <= 10'(OSC_PER_INSTR * i_delay) - 10'h001;
            end
          end else if (busy) begin
            if (cnt == 10'h000) begin
              busy <= 1'b0;
              o_out[g] <= 1'b1;
            end else begin
              cnt <= cnt - 10'h001;
            end
          end
        end
      end
    end
  endgenerate

endmodule

// [core/bpd_top.sv]
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// - Period is 4 osc times (period+1) times prescale.
// - Ten-bit duty from duty byte and control bits.
// - Period ends where timer equals period register.
// - Half-bridge: A is PWM, B its complement.
// - Half-bridge active edges delayed by delay count.
// - Delay applies only to inactive-to-active edges.
// - Delay longer than pulse keeps output inactive.
// - Forward: A held active, D modulated.
// - Reverse: C held active, B modulated.
// - Direction bit takes effect next PWM cycle.
// - A and C switch early by prescale osc periods.
// - B and D inactive during direction transition.
// - Full-bridge uses no dead-band delay.
// - Flag set after full cycle; outputs then valid.
// - Mode low bits choose output polarity.
// - New cycle starts at overflow, with the flag.
// - Control values double-buffered, loaded at overflow.
// - Delay loaded at duty or period boundary.
module bpd_top
  import bpd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [3:0] o_bridge_out,
  output logic [3:0] o_bridge_oe
);

  // ----------------------------------------------------------------
  // Register bus.
  // ----------------------------------------------------------------
  bpd_wr_type wr;          // One-cycle register write.
  logic [7:0] rd_addr;     // Address being read.
  logic [31:0] rd_data;    // Read data for that address.

  bpd_axil u_axil (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_wr(wr),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // Software registers.
  // ----------------------------------------------------------------
  logic [7:0] pwm_control_reg;      // Config, duty low bits, mode.
  logic [7:0] duty_high_reg;        // Upper eight duty bits.
  logic [7:0] period_reg;           // Period compare value.
  logic [2:0] period_timer_control; // Timer on and prescale.
  logic [7:0] deadband_delay_reg;   // delay_count.
  logic [3:0] pin_direction_reg;    // One means pin is an input.
  logic period_timer_flag;          // Set on every overflow.
  logic [7:0] period_timer;         // Running period timer.
  logic wr_lo;                      // Write that hits the low byte.
  logic ovf;                        // Last clock of a PWM period.

  assign wr_lo = wr.en && wr.strb[0];
  // Plain read-write registers; only the low byte is kept.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_control_reg <= RST_CTRL;
      duty_high_reg <= RST_DUTY;
      period_reg <= RST_PERIOD;
      period_timer_control <= RST_TCTRL;
      deadband_delay_reg <= RST_DELAY;
      pin_direction_reg <= RST_PINDIR;
    end else if (i_ce && wr_lo) begin
      case (wr.addr)
        OFF_CTRL: begin
          pwm_control_reg <= wr.data[7:0];
        end
        OFF_DUTY: begin
          duty_high_reg <= wr.data[7:0];
        end
        OFF_PERIOD: begin
          period_reg <= wr.data[7:0];
        end
        OFF_TCTRL: begin
          period_timer_control <= wr.data[2:0];
        end
        OFF_DELAY: begin
          deadband_delay_reg <= wr.data[7:0];
        end
        OFF_PINDIR: begin
          pin_direction_reg <= wr.data[3:0];
        end
        default: begin
          // Other addresses hold no plain register.
        end
      endcase
    end
  end

  // Flag: written directly by software, an overflow wins over a clear.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      period_timer_flag <= 1'b0;
    end else if (i_ce) begin
      if (ovf) begin
        period_timer_flag <= 1'b1;
      end else if (wr_lo && wr.addr == OFF_FLAG) begin
        period_timer_flag <= wr.data[0];
      end
    end
  end

  // Read multiplexer; narrow registers sit in the low bits.
  always_comb begin
    case (rd_addr)
      OFF_CTRL: rd_data = {24'h0, pwm_control_reg};
      OFF_DUTY: rd_data = {24'h0, duty_high_reg};
      OFF_PERIOD: rd_data = {24'h0, period_reg};
      OFF_TCTRL: rd_data = {29'h0, period_timer_control};
      OFF_FLAG: rd_data = {31'h0, period_timer_flag};
      OFF_DELAY: rd_data = {24'h0, deadband_delay_reg};
      OFF_TIMER: rd_data = {24'h0, period_timer};
      OFF_PINDIR: rd_data = {28'h0, pin_direction_reg};
      default: rd_data = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Period timer with prescaler.
  // ----------------------------------------------------------------
  logic timer_on;      // period_timer_on.
  logic [1:0] pscale;  // prescale_select.
  logic [5:0] pre_cnt; // Oscillator periods within one timer step.
  logic [5:0] pre_max; // Last value of pre_cnt.
  logic [1:0] sub;     // Quarter of a timer step, duty resolution.
  logic tick;          // Timer steps on this clock.
  logic [9:0] pos;     // Position in the period, duty units.

  assign timer_on = period_timer_control[TCTRL_ON_BIT];
  assign pscale = period_timer_control[1:0];

  // One timer step is 4, 16 or 64 oscillator periods.
  always_comb begin
    case (pscale)
      2'h0: begin
        pre_max = 6'h03;
        sub = pre_cnt[1:0];
      end
      2'h1: begin
        pre_max = 6'h0F;
        sub = pre_cnt[3:2];
      end
      default: begin
        pre_max = 6'h3F;
        sub = pre_cnt[5:4];
      end
    endcase
  end

  assign tick = timer_on && (pre_cnt == pre_max);
  assign ovf = tick && (period_timer == period_reg);
  assign pos = {period_timer, sub};

  // Timer counts 0..period, then restarts: (period+1) steps.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_cnt <= 6'h00;
      period_timer <= 8'h00;
    end else if (i_ce && timer_on) begin
      pre_cnt <= tick ? 6'h00 : pre_cnt + 6'h01;
      if (ovf) begin
        period_timer <= 8'h00;
      end else if (tick) begin
        period_timer <= period_timer + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffered control, loaded at each period boundary.
  // ----------------------------------------------------------------
  logic [1:0] sh_cfg;   // Active output configuration.
  logic [3:0] sh_mode;  // Active module mode and polarity.
  logic [9:0] sh_duty;  // Active ten-bit duty.
  logic [7:0] sh_delay; // Active dead-band delay.
  logic pwm_raw;        // Modulated signal, active level.
  logic pwm_prev;       // pwm_raw one cycle ago.
  logic duty_end;       // Duty boundary of this period.

  assign pwm_raw = pos < sh_duty;
  assign duty_end = pwm_prev && !pwm_raw;

  // Outputs change from buffered copies, except live_cfg during the early switch, so none glitch.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sh_cfg <= CFG_SINGLE;
      sh_mode <= 4'h0;
      sh_duty <= 10'h000;
    end else if (i_ce && ovf) begin
      sh_cfg <= pwm_control_reg[CTRL_CFG_LSB +: 2];
      sh_mode <= pwm_control_reg[3:0];
      sh_duty <= {duty_high_reg, pwm_control_reg[CTRL_DLO_LSB +: 2]};
    end
  end

  // Delay copy is reloaded at every boundary, the duty end and the overflow.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_prev <= 1'b0;
      sh_delay <= RST_DELAY;
    end else if (i_ce) begin
      pwm_prev <= pwm_raw;
      if (ovf || duty_end) begin
        sh_delay <= deadband_delay_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Direction change sequencer.
  // ----------------------------------------------------------------
  bpd_dir_state_type state;
  bpd_dir_state_type next_state;
  logic [1:0] live_cfg; // Configuration just written.
  logic full_now;       // Full bridge in the running cycle.
  logic turn_start;     // Start of the early switch interval.
  logic turn_rev;       // New direction is reverse.

  assign live_cfg = pwm_control_reg[CTRL_CFG_LSB +: 2];
  assign full_now = (sh_cfg == CFG_FWD) || (sh_cfg == CFG_REV);
  // The last quarter of the last step lasts 1, 4 or 16 osc periods.
  assign turn_start = timer_on && full_now && live_cfg[0] &&
    (live_cfg[1] != sh_cfg[1]) && (period_timer == period_reg) &&
    (sub == 2'h3);

  always_comb begin
    case (state)
      ST_RUN: next_state = (turn_start && !ovf) ? ST_TURN : ST_RUN;
      ST_TURN: next_state = ovf ? ST_RUN : ST_TURN;
      default: next_state = ST_RUN;
    endcase
  end

  // The sequencer holds its new direction for the whole interval.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_RUN;
      turn_rev <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      if (state == ST_RUN && turn_start) begin
        turn_rev <= live_cfg[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Dead band for the half-bridge pair.
  // ----------------------------------------------------------------
  logic half_mode;   // Half-bridge configuration is running.
  logic [1:0] db_out; // Delayed A and B, active level.

  assign half_mode = sh_cfg == CFG_HALF;

  bpd_deadband u_deadband (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_enable(half_mode),
    .i_delay(sh_delay),
    .i_raw({!pwm_raw, pwm_raw}),
    .o_out(db_out)
  );

  // ----------------------------------------------------------------
  // Output steering and polarity.
  // ----------------------------------------------------------------
  logic [3:0] act;       // Active levels of A, B, C, D.
  logic [3:0] next_out;  // Pin levels after polarity.
  logic enabled;         // Module is in PWM mode.

  assign enabled = sh_mode[3:2] == PWM_MODE_ON;

  // Bit 0 is A, 1 is B, 2 is C, 3 is D.
  always_comb begin
    act = 4'h0;
    if (turn_start || state == ST_TURN) begin
      // A and C move to the new side early; B and D stay off.
      act[0] = (state == ST_TURN) ? !turn_rev : !live_cfg[1];
      act[2] = (state == ST_TURN) ? turn_rev : live_cfg[1];
    end else begin
      case (sh_cfg)
        CFG_SINGLE: begin
          act[0] = pwm_raw;
        end
        CFG_FWD: begin
          act[0] = 1'b1;
          act[3] = pwm_raw;
        end
        CFG_HALF: begin
          act[1:0] = db_out;
        end
        CFG_REV: begin
          act[2] = 1'b1;
          act[1] = pwm_raw;
        end
        default: begin
          act = 4'h0;
        end
      endcase
    end
    // Polarity: bit 1 inverts A and C, bit 0 inverts B and D.
    next_out[0] = act[0] ^ sh_mode[1];
    next_out[2] = act[2] ^ sh_mode[1];
    next_out[1] = act[1] ^ sh_mode[0];
    next_out[3] = act[3] ^ sh_mode[0];
    if (!enabled) begin
      next_out = 4'h0;
    end
  end

  // Pins are driven only where the direction bit is cleared.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bridge_out <= 4'h0;
      o_bridge_oe <= 4'h0;
    end else if (i_ce) begin
      o_bridge_out <= next_out;
      o_bridge_oe <= ~pin_direction_reg;
    end
  end

endmodule

// [sim/bpd_switch_model.sv]
`timescale 1ns/100ps
// Gate drivers of a two-leg bridge; leg one is A and B, leg two is C and D.
module bpd_switch_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_pin,
  input wire logic [3:0] i_oe,
  output logic [3:0] o_gate,
  output logic o_shoot
);
  // A released pin is held low by its pull-down, so that switch stays off.
  assign o_gate = i_pin & i_oe;
  // Sticky flag: both switches of one leg on at the same time.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_shoot <= 1'h0;
    end else if ((o_gate[0] && o_gate[1]) || (o_gate[2] && o_gate[3])) begin
      o_shoot <= 1'h1;
    end
  end
endmodule

// [sim/bpd_chk.sv]
`timescale 1ns/100ps
module bpd_chk
  import bpd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [3:0] o_bridge_out,
  input wire logic [3:0] o_bridge_oe
);
  logic [7:0] ctl; // Shadow of the control register.
  logic [7:0] cnt; // Cycles since the last register write.
  logic wh; // A write is taken.
  logic [3:0] raw; // Output levels with polarity removed.
  logic s; // Module enabled and settled.
  assign wh = i_awvalid && o_awready && i_wvalid && o_wready;
  assign raw = o_bridge_out ^ {ctl[0], ctl[1], ctl[0], ctl[1]};
  assign s = (cnt == 8'hFF) && (ctl[3:2] == PWM_MODE_ON);
  // Shadow of control writes.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl <= 8'h00;
    end else if (wh && (i_awaddr == OFF_CTRL) && i_wstrb[0]) begin
      ctl <= i_wdata[7:0];
    end
  end
  // Cycles since the last write, saturating.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 8'h00;
    end else if (wh) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hFF) begin
      cnt <= cnt + 8'h01;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_fwd; s && ctl[7:6] == CFG_FWD |-> raw[0] && raw[2:1] == 2'h0; endproperty
  a_fwd: assert property (p_fwd) else $error("forward outputs wrong");
  property p_rev; s && ctl[7:6] == CFG_REV |-> raw[2] && !raw[0] && !raw[3]; endproperty
  a_rev: assert property (p_rev) else $error("reverse outputs wrong");
  property p_half; s && ctl[7:6] == CFG_HALF |-> !(raw[0] && raw[1]); endproperty
  a_half: assert property (p_half) else $error("half bridge overlap");
  property p_single; s && ctl[7:6] == CFG_SINGLE |-> raw[3:1] == 3'h0; endproperty
  a_single: assert property (p_single) else $error("single mode extra output");
  property p_off; cnt == 8'hFF && ctl[3:2] != PWM_MODE_ON |-> o_bridge_out == 4'h0; endproperty
  a_off: assert property (p_off) else $error("disabled module drives outputs");
  property p_turn; $fell(raw[0]) && $rose(raw[2]) |-> raw[1] == 1'h0 && raw[3] == 1'h0; endproperty
  a_turn: assert property (p_turn) else $error("modulated output active at turn");
  property p_wans; i_awvalid && o_awready |-> o_wready ##1 o_bvalid; endproperty
  a_wans: assert property (p_wans) else $error("write answer late");
  property p_bdrop; o_bvalid && i_bready |=> !o_bvalid; endproperty
  a_bdrop: assert property (p_bdrop) else $error("write response held");
  property p_rans; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rdrop; o_rvalid && i_rready |=> !o_rvalid; endproperty
  a_rdrop: assert property (p_rdrop) else $error("read data held");
  property p_oe; $rose(i_rstn) |-> o_bridge_oe == 4'h0; endproperty
  a_oe: assert property (p_oe) else $error("pins driven after reset");
  c_fwd: cover property (s && ctl[7:6] == CFG_FWD);
  c_rev: cover property (s && ctl[7:6] == CFG_REV);
  c_turn: cover property ($fell(raw[0]) && $rose(raw[2]));
endmodule
bind bpd_top bpd_chk i_bpd_chk(.i_clk, .i_rstn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
  .i_wstrb, .i_wvalid, .o_wready, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid,
  .i_rready, .o_bridge_out, .o_bridge_oe);

// [sim/testbench.sv]
`timescale 1ns/100ps
module testbench
  import bpd_pkg::*;
;
  logic i_clk, i_rstn, i_ce, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [3:0] i_wstrb, o_bridge_out, o_bridge_oe, gate;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, shoot;
  logic [1:0] o_bresp, o_rresp, r;
  int mismatches, samples_checked, cycles, hi, per;
  bpd_top i_bpd_top(.i_clk, .i_rstn, .i_ce, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_bridge_out, .o_bridge_oe);
  bpd_switch_model i_bpd_switch_model(.i_clk, .i_rstn, .i_pin(o_bridge_out),
    .i_oe(o_bridge_oe), .o_gate(gate), .o_shoot(shoot));
  // Clock of 5 ns.
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  // A hang counts as a mismatch.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      conclude;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus write; both channels offered together and released as taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit pa = 1, pw = 1;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    while (pa || pw) begin
      @(posedge i_clk);
      if (pa && o_awready) begin
        i_awvalid <= 1'h0;
        pa = 0;
      end
      if (pw && o_wready) begin
        i_wvalid <= 1'h0;
        pw = 0;
      end
    end
    while (o_bvalid !== 1'h1) @(posedge i_clk);
    r = o_bresp;
    i_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do @(posedge i_clk); while (o_arready !== 1'h1);
    i_arvalid <= 1'h0;
    do @(posedge i_clk); while (o_rvalid !== 1'h1);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'h0;
  endtask
  // High time and period of one output, in clocks.
  task automatic meas(input int b);
    while (o_bridge_out[b] !== 1'h0) @(posedge i_clk);
    while (o_bridge_out[b] !== 1'h1) @(posedge i_clk);
    hi = 0;
    while (o_bridge_out[b] === 1'h1) begin
      @(posedge i_clk);
      hi++;
    end
    per = hi;
    while (o_bridge_out[b] === 1'h0) begin
      @(posedge i_clk);
      per++;
    end
  endtask
  // Setup in the safe order: settings, flag clear, then timer on.
  task automatic cfg(input logic [7:0] c, du, pr, dl, input logic [2:0] tc);
    wr(OFF_CTRL, {24'h0, c});
    wr(OFF_DUTY, {24'h0, du});
    wr(OFF_PERIOD, {24'h0, pr});
    wr(OFF_DELAY, {24'h0, dl});
    wr(OFF_FLAG, 32'h0);
    wr(OFF_TCTRL, {29'h0, tc});
  endtask
  task automatic t_regs;
    rd(OFF_DELAY);
    chk(d, 32'h0);
    wr(OFF_DELAY, 32'h5A);
    rd(OFF_DELAY);
    chk(d, 32'h5A);
    wr(8'h20, 32'h1);
    chk(r, RESP_SLVERR);
    rd(8'h20);
    chk(r, RESP_SLVERR);
    wr(OFF_FLAG, 32'h0);
    rd(OFF_FLAG);
    chk(d, 32'h0);
    repeat (260) @(posedge i_clk);
    chk({o_bridge_oe, o_bridge_out}, 32'h0);
    $display("regs done");
  endtask
  task automatic t_period;
    cfg(8'h0C, 8'h01, 8'h01, 8'h00, 3'h4);
    do rd(OFF_FLAG); while (d[0] !== 1'h1);
    meas(0);
    meas(0);
    chk(hi, 4);
    chk(per, 8);
    repeat (260) @(posedge i_clk);
    wr(OFF_TCTRL, 32'h5);
    meas(0);
    meas(0);
    chk(hi, 16);
    chk(per, 32);
    $display("period done");
  endtask
  task automatic t_half;
    cfg(8'h8C, 8'h04, 8'h07, 8'h01, 3'h4);
    meas(0);
    meas(0);
    chk(hi, 12);
    chk(per, 32);
    meas(1);
    chk(hi, 12);
    wr(OFF_PINDIR, 32'h0);
    repeat (260) @(posedge i_clk);
    chk(o_bridge_oe, 4'hF);
    chk(shoot, 1'h0);
    wr(OFF_DELAY, 32'h5);
    repeat (64) @(posedge i_clk);
    hi = 0;
    repeat (256) begin
      @(posedge i_clk);
      if (o_bridge_out[0] !== 1'h0) hi++;
    end
    chk(hi, 0);
    wr(OFF_PINDIR, 32'hF);
    $display("half done");
  endtask
  task automatic t_bridge;
    cfg(8'h4E, 8'h02, 8'h07, 8'h03, 3'h4);
    meas(3);
    meas(3);
    chk(hi, 8);
    chk(per, 32);
    chk(o_bridge_out[2:0], 3'h4);
    repeat (260) @(posedge i_clk);
    wr(OFF_CTRL, 32'hCE);
    while (o_bridge_out[2] !== 1'h0) @(posedge i_clk);
    for (hi = 0; o_bridge_out[1] !== 1'h1; hi++) @(posedge i_clk);
    chk(hi, 1);
    meas(1);
    meas(1);
    chk(hi, 8);
    chk({o_bridge_out[3:2], o_bridge_out[0]}, 3'h1);
    repeat (260) @(posedge i_clk);
    $display("bridge done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h0;
    {i_awaddr, i_araddr, i_wdata} = 48'h0;
    i_wstrb = 4'hF;
    i_ce = 1'h1;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'h1;
    t_regs;
    t_period;
    t_half;
    t_bridge;
    conclude;
  end
endmodule
